// file: src/dbu_debug_breakpoint_unit.sv
// Debug breakpoint unit: address matching, traps, status and Avalon slave
`timescale 1ns/10ps
module dbu_debug_breakpoint_unit
  import dbu_pkg::*;
(
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic clk_en_in,
  // Avalon-MM slave
  input wire logic [dbu_pkg::BUS_AW-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Instruction about to execute
  input wire logic start_in,
  input wire logic [dbu_pkg::VA_W-1:0] start_ip_in,
  input wire logic dr_access_in,
  // Instruction completed
  input wire logic retire_in,
  input wire logic [dbu_pkg::VA_W-1:0] retire_ip_in,
  input wire logic [dbu_pkg::VA_W-1:0] next_ip_in,
  input wire logic rep_incomplete_in,
  input wire logic sets_tf_in,
  input wire logic mem_valid_in,
  input wire logic mem_write_in,
  input wire logic [dbu_pkg::VA_W-1:0] mem_addr_in,
  input wire logic [1:0] mem_size_in,
  input wire logic io_valid_in,
  input wire logic [dbu_pkg::PORT_W-1:0] io_port_in,
  input wire logic [1:0] io_size_in,
  input wire logic task_switch_in,
  input wire logic swap_break_in,
  input wire logic ext_irq_in,
  // Exception request to the pipeline
  output logic exc_valid_out,
  output logic [7:0] exc_vector_out,
  output logic exc_before_out,
  output logic [dbu_pkg::VA_W-1:0] exc_ret_ip_out,
  output logic exc_tf_image_out,
  output logic exc_irq_next_out,
  output logic step_trap_flag_out,
  output logic resume_flag_out
);
  import dbu_pkg::*;

  // Low bits ignored for a given size code
  function automatic logic [2:0] size_mask(input logic [1:0] sz);
    case (sz)
      2'h0: size_mask = 3'h0;
      2'h1: size_mask = 3'h1;
      2'h3: size_mask = 3'h3;
      default: size_mask = 3'h7;
    endcase
  endfunction

  // Any byte of the access lies inside the aligned breakpoint range
  function automatic logic range_hit(input logic [VA_W-1:0] bp,
      input logic [1:0] sz, input logic [VA_W-1:0] a, input logic [1:0] asz);
    logic [VA_W-1:0] lo;
    logic [VA_W-1:0] hi;
    logic [VA_W-1:0] aend;
    lo = bp & ~{61'h0, size_mask(sz)};
    hi = lo | {61'h0, size_mask(sz)};
    aend = a + {61'h0, (3'h1 << asz) - 3'h1};
    range_hit = (a <= hi) && (aend >= lo);
  endfunction

  // Merge a bus write word under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    be_merge = r;
  endfunction

  logic [VA_W-1:0] bp_addr_r [NUM_BP];
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [31:0] stat_r;
  logic [31:0] stat_nxt;
  logic [2:0] flags_r;
  logic [2:0] flags_nxt;
  logic [1:0] skip_r;
  logic [1:0] skip_nxt;
  dbu_bus_e bus_r;
  logic [31:0] rdata_r;
  logic exc_valid_r;
  logic exc_before_r;
  logic [VA_W-1:0] exc_ret_ip_r;
  logic exc_tf_image_r;
  logic exc_irq_next_r;

  // Bus decode: one wait state, write lands on the acknowledge edge
  wire bus_req = avs_read_in | avs_write_in;
  wire bus_wr = avs_write_in && (bus_r == BUS_ACK) && clk_en_in;
  wire in_bp = (avs_address_in & 6'h20) == OFF_BP_BASE;
  wire [1:0] bp_sel = avs_address_in[4:3];
  wire bp_hi = avs_address_in[2];
  wire wr_ctrl = bus_wr && (avs_address_in == OFF_CTRL);
  wire wr_stat = bus_wr && (avs_address_in == OFF_STAT);
  wire wr_flags = bus_wr && (avs_address_in == OFF_FLAGS);
  wire [VA_W-1:0] sel_bp = bp_addr_r[bp_sel];
  wire [31:0] sel_word = bp_hi ? sel_bp[63:32] : sel_bp[31:0];
  wire [31:0] rd_mux = in_bp ? sel_word :
    (avs_address_in == OFF_CTRL) ? ctrl_r :
    (avs_address_in == OFF_STAT) ? stat_r :
    (avs_address_in == OFF_FLAGS) ? {29'h0, flags_r} : 32'h0;
  wire guard_r = ctrl_r[CTRL_GUARD_POS];
  wire tf_r = flags_r[FLAG_TF];
  wire rf_r = flags_r[FLAG_RF];
  wire ioen_r = flags_r[FLAG_IOEN];

  // Per-breakpoint matching, all four in parallel
  wire [NUM_BP-1:0] ibp_hit;
  wire [NUM_BP-1:0] dbp_hit;
  wire [NUM_BP-1:0] iobp_hit;
  wire [VA_W-1:0] port_va = {{(VA_W-PORT_W){1'b0}}, io_port_in};
  genvar g;
  generate
    for (g = 0; g < NUM_BP; g++) begin : g_bp
      wire [1:0] at = ctrl_r[CTRL_TYPE_POS + CTRL_FIELD_STRIDE*g +: 2];
      wire [1:0] sz = ctrl_r[CTRL_TYPE_POS + CTRL_FIELD_STRIDE*g
        + CTRL_SIZE_OFS +: 2];
      wire en = ctrl_r[2*g] | ctrl_r[2*g+1];
      wire acc_ok = (at == AT_RW) || ((at == AT_WRITE) && mem_write_in);
      // Instruction compare uses a single-byte range
      assign ibp_hit[g] = en && (at == AT_EXEC) &&
        range_hit(bp_addr_r[g], 2'h0, start_ip_in, 2'h0);
      // Write-only or read/write data match over the sized range
      assign dbp_hit[g] = en && mem_valid_in && acc_ok &&
        range_hit(bp_addr_r[g], sz, mem_addr_in, mem_size_in);
      // Port match only with I/O enable; size picks the operation width
      assign iobp_hit[g] = en && io_valid_in && ioen_r &&
        (at == AT_IO) && range_hit(bp_addr_r[g], sz, port_va, io_size_in);
    end
  endgenerate

  // Exception sources after completion of the retiring instruction
  wire step_fire = retire_in && tf_r && !sets_tf_in && skip_r == 2'h0;
  wire post_bp = retire_in && (|dbp_hit || |iobp_hit);
  wire post_ts = retire_in && task_switch_in && swap_break_in;
  wire post_exc = post_bp || post_ts || step_fire;
  // Exception sources before execution of the starting instruction
  wire pre_ibp = start_in && !rf_r && |ibp_hit;
  wire pre_guard = start_in && dr_access_in && guard_r;
  wire pre_exc = (pre_ibp || pre_guard) && !post_exc;
  wire any_exc = post_exc || pre_exc;
  // Return address: unfinished string repeats itself
  wire [VA_W-1:0] post_ret = rep_incomplete_in ? retire_ip_in : next_ip_in;
  wire [VA_W-1:0] ret_ip = post_exc ? post_ret : start_ip_in;

  // Control next value: bus write, then hardware updates win
  always_comb begin
    ctrl_nxt = wr_ctrl ? be_merge(ctrl_r, avs_writedata_in,
      avs_byteenable_in) : ctrl_r;
    if (retire_in && task_switch_in) begin
      ctrl_nxt = ctrl_nxt & ~CTRL_LOCAL_MASK;
    end
    if (pre_exc && pre_guard) begin
      ctrl_nxt[CTRL_GUARD_POS] = 1'b0;
    end
  end

  // Status next value: hardware sets win over software writes
  always_comb begin
    stat_nxt = wr_stat ? be_merge(stat_r, avs_writedata_in,
      avs_byteenable_in) : stat_r;
    if (post_exc) begin
      stat_nxt[NUM_BP-1:0] = stat_nxt[NUM_BP-1:0] |
        (retire_in ? (dbp_hit | iobp_hit) : 4'h0);
      stat_nxt[STAT_STEP_HIT] = stat_nxt[STAT_STEP_HIT] | step_fire;
      stat_nxt[STAT_TS_HIT] = stat_nxt[STAT_TS_HIT] | post_ts;
    end else if (pre_exc) begin
      stat_nxt[NUM_BP-1:0] = stat_nxt[NUM_BP-1:0] |
        (rf_r ? 4'h0 : ibp_hit);
      stat_nxt[STAT_GUARD_HIT] = stat_nxt[STAT_GUARD_HIT] | pre_guard;
    end
  end

  // Flags next value: step flag, resume flag, I/O enable
  always_comb begin
    flags_nxt = wr_flags ? avs_writedata_in[2:0] : flags_r;
    skip_nxt = skip_r;
    if (retire_in) begin
      flags_nxt[FLAG_RF] = 1'b0;
      skip_nxt = (skip_r != 2'h0) ? skip_r - 2'h1 : 2'h0;
      if (sets_tf_in) begin
        flags_nxt[FLAG_TF] = 1'b1;
        skip_nxt = STEP_SKIP;
      end
    end
    if (step_fire) begin
      flags_nxt[FLAG_TF] = 1'b0;
    end
  end

  // Register file and breakpoint addresses
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < NUM_BP; i++) begin
        bp_addr_r[i] <= '0;
      end
      ctrl_r <= CTRL_RST;
      stat_r <= STAT_RST;
      flags_r <= FLAGS_RST;
      skip_r <= 2'h0;
    end else if (clk_en_in) begin
      if (bus_wr && in_bp && bp_hi) begin
        bp_addr_r[bp_sel][63:32] <= be_merge(sel_bp[63:32],
          avs_writedata_in, avs_byteenable_in);
      end
      if (bus_wr && in_bp && !bp_hi) begin
        bp_addr_r[bp_sel][31:0] <= be_merge(sel_bp[31:0],
          avs_writedata_in, avs_byteenable_in);
      end
      ctrl_r <= ctrl_nxt;
      stat_r <= stat_nxt;
      flags_r <= flags_nxt;
      skip_r <= skip_nxt;
    end
  end

  // Bus handshake: capture read data, acknowledge next cycle
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bus_r <= BUS_IDLE;
      rdata_r <= 32'h0;
    end else if (clk_en_in) begin
      case (bus_r)
        BUS_IDLE: begin
          if (bus_req) begin
            bus_r <= BUS_ACK;
            rdata_r <= avs_read_in ? rd_mux : 32'h0;
          end
        end
        BUS_ACK: bus_r <= BUS_IDLE;
        default: bus_r <= BUS_IDLE;
      endcase
    end
  end

  // Exception request toward the pipeline
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      exc_valid_r <= 1'b0;
      exc_before_r <= 1'b0;
      exc_ret_ip_r <= '0;
      exc_tf_image_r <= 1'b0;
      exc_irq_next_r <= 1'b0;
    end else if (clk_en_in) begin
      exc_valid_r <= any_exc;
      if (any_exc) begin
        exc_before_r <= !post_exc;
        exc_ret_ip_r <= ret_ip;
        exc_tf_image_r <= tf_r; // Pushed image keeps the step flag
        exc_irq_next_r <= step_fire && ext_irq_in;
      end
    end
  end

  assign avs_waitrequest_out = bus_req && !((bus_r == BUS_ACK) && clk_en_in);
  assign avs_readdata_out = rdata_r;
  assign exc_valid_out = exc_valid_r;
  assign exc_vector_out = DBG_VECTOR;
  assign exc_before_out = exc_before_r;
  assign exc_ret_ip_out = exc_ret_ip_r;
  assign exc_tf_image_out = exc_tf_image_r;
  assign exc_irq_next_out = exc_irq_next_r;
  assign step_trap_flag_out = tf_r;
  assign resume_flag_out = rf_r;

  // Checks on the unit's own behaviour
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_step_cause;
    clk_en_in && step_fire;
  endsequence
  sequence s_step_entry;
    exc_valid_out && !exc_before_out && exc_tf_image_out && !tf_r;
  endsequence

  a_vector_one: assert property (
    exc_valid_out |-> exc_vector_out == 8'h01)
    else $error("debug exception not on vector 1");
  a_step_entry: assert property (
    s_step_cause |=> s_step_entry ##0 stat_r[STAT_STEP_HIT])
    else $error("step trap entry wrong");
  a_post_first: assert property (
    clk_en_in && post_exc && pre_ibp |=> exc_valid_out && !exc_before_out)
    else $error("instruction trap beat a completion trap");
  a_ibp_before: assert property (
    clk_en_in && pre_ibp && !post_exc |=> exc_valid_out && exc_before_out
      && exc_ret_ip_out == $past(start_ip_in))
    else $error("instruction trap not raised before execution");
  a_resume_mask: assert property (
    clk_en_in && start_in && rf_r && !dr_access_in && !post_exc
      |=> !exc_valid_out)
    else $error("resume flag did not mask instruction trap");
  a_resume_clear: assert property (
    clk_en_in && retire_in |=> !rf_r)
    else $error("resume flag not cleared after instruction");
  a_guard_trap: assert property (
    clk_en_in && pre_guard && !post_exc
      |=> !guard_r && stat_r[STAT_GUARD_HIT] && exc_before_out)
    else $error("guard trap wrong");
  a_local_clear: assert property (
    clk_en_in && retire_in && task_switch_in
      |=> (ctrl_r & CTRL_LOCAL_MASK) == 32'h0)
    else $error("local enables survived task switch");
  a_data_ret: assert property (
    clk_en_in && post_bp && !rep_incomplete_in
      |=> exc_valid_out && exc_ret_ip_out == $past(next_ip_in))
    else $error("data trap return address wrong");
  // Remembers that the last retired instruction set the step flag
  logic setter_seen_r;
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      setter_seen_r <= 1'b0;
    end else if (clk_en_in && retire_in) begin
      setter_seen_r <= sets_tf_in;
    end
  end
  // Completion hits of all four breakpoints
  wire [NUM_BP-1:0] post_hits = dbp_hit | iobp_hit;

  a_step_skip: assert property (
    clk_en_in && retire_in && (sets_tf_in || setter_seen_r) && !post_bp
      && !post_ts && !pre_ibp && !pre_guard |=> !exc_valid_out)
    else $error("step trap on setter or following instruction");
  a_task_trap: assert property (
    clk_en_in && post_ts |=> exc_valid_out && !exc_before_out
      && stat_r[STAT_TS_HIT])
    else $error("task switch trap wrong");
  a_data_hit: assert property (
    clk_en_in && post_bp |=> exc_valid_out
      && ((stat_r[NUM_BP-1:0] & $past(post_hits)) == $past(post_hits)))
    else $error("data or port hit bit not set");
  a_bus_ack: assert property (
    clk_en_in && bus_req && avs_waitrequest_out
      |=> !clk_en_in || !avs_waitrequest_out)
    else $error("bus acknowledge late");

endmodule // dbu_debug_breakpoint_unit

// file: src/dbu_pkg.sv
// Constants, register map and field layout of the debug breakpoint unit
package dbu_pkg;
  localparam int NUM_BP = 4;
  localparam int VA_W = 64;
  localparam int BUS_AW = 6;
  localparam int PORT_W = 16;
  // Register byte offsets; breakpoint n low word at n*8, high word at n*8+4
  localparam logic [5:0] OFF_BP_BASE = 6'h00;
  localparam logic [5:0] OFF_CTRL = 6'h20;
  localparam logic [5:0] OFF_STAT = 6'h24;
  localparam logic [5:0] OFF_FLAGS = 6'h28;
  // Control register fields
  localparam int CTRL_GUARD_POS = 13;
  localparam int CTRL_TYPE_POS = 16;
  localparam int CTRL_FIELD_STRIDE = 4;
  localparam int CTRL_SIZE_OFS = 2;
  localparam logic [31:0] CTRL_LOCAL_MASK = 32'h0000_0055;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // Status register fields
  localparam int STAT_GUARD_HIT = 13;
  localparam int STAT_STEP_HIT = 14;
  localparam int STAT_TS_HIT = 15;
  localparam logic [31:0] STAT_RST = 32'h0000_0000;
  // Flags register fields
  localparam int FLAG_TF = 0;
  localparam int FLAG_RF = 1;
  localparam int FLAG_IOEN = 2;
  localparam logic [2:0] FLAGS_RST = 3'h0;
  // Exception vector
  localparam logic [7:0] DBG_VECTOR = 8'h01;
  // Access type encodings
  localparam logic [1:0] AT_EXEC = 2'h0;
  localparam logic [1:0] AT_WRITE = 2'h1;
  localparam logic [1:0] AT_IO = 2'h2;
  localparam logic [1:0] AT_RW = 2'h3;
  // Steps to skip after the instruction that sets the step trap flag
  localparam logic [1:0] STEP_SKIP = 2'h1;
  typedef enum logic {BUS_IDLE = 1'b0, BUS_ACK = 1'b1} dbu_bus_e;
endpackage

// file: testbench/dbu_pipe_model.sv
// Pipeline model: presents instructions before and after execution
`timescale 1ns/10ps
module dbu_pipe_model (
  input wire logic clock_in,
  output logic start_in,
  output logic [dbu_pkg::VA_W-1:0] start_ip_in,
  output logic dr_access_in,
  output logic retire_in,
  output logic [dbu_pkg::VA_W-1:0] retire_ip_in,
  output logic [dbu_pkg::VA_W-1:0] next_ip_in,
  output logic rep_incomplete_in,
  output logic sets_tf_in,
  output logic mem_valid_in,
  output logic mem_write_in,
  output logic [dbu_pkg::VA_W-1:0] mem_addr_in,
  output logic [1:0] mem_size_in,
  output logic io_valid_in,
  output logic [dbu_pkg::PORT_W-1:0] io_port_in,
  output logic [1:0] io_size_in,
  output logic task_switch_in,
  output logic swap_break_in,
  output logic ext_irq_in
);
  import dbu_pkg::*;
  // Everything idle at time zero
  initial begin
    {start_in, start_ip_in, dr_access_in, retire_in, retire_ip_in} = '0;
    {next_ip_in, rep_incomplete_in, sets_tf_in, mem_valid_in} = '0;
    {mem_write_in, mem_addr_in, mem_size_in, io_valid_in} = '0;
    {io_port_in, io_size_in, task_switch_in, swap_break_in, ext_irq_in} = '0;
  end
  // One instruction about to execute, held for one cycle
  task automatic pre(input logic [63:0] ip, input logic dra);
    @(posedge clock_in);
    start_in <= 1'b1;
    start_ip_in <= ip;
    dr_access_in <= dra;
    @(posedge clock_in);
    start_in <= 1'b0;
    start_ip_in <= ~ip; // Released address shows no stale value
    dr_access_in <= 1'b0;
  endtask
  // One retired instruction; f = irq,swap,switch,settf,rep,io,mem,write
  task automatic post(input logic [63:0] ip, input logic [7:0] f,
                      input logic [63:0] a, input logic [1:0] sz);
    @(posedge clock_in);
    retire_in <= 1'b1;
    retire_ip_in <= ip;
    next_ip_in <= ip + 64'h4;
    {ext_irq_in, swap_break_in, task_switch_in, sets_tf_in} <= f[7:4];
    {rep_incomplete_in, io_valid_in, mem_valid_in, mem_write_in} <= f[3:0];
    mem_addr_in <= a;
    io_port_in <= a[15:0];
    mem_size_in <= sz;
    io_size_in <= sz;
    @(posedge clock_in);
    retire_in <= 1'b0;
    {ext_irq_in, swap_break_in, task_switch_in, sets_tf_in} <= 4'h0;
    {rep_incomplete_in, io_valid_in, mem_valid_in, mem_write_in} <= 4'h0;
    mem_addr_in <= ~a;
    io_port_in <= ~a[15:0];
  endtask
endmodule // dbu_pipe_model

// file: testbench/dbu_debug_breakpoint_unit_tb.sv
// Self-checking bench for the debug breakpoint unit
`timescale 1ns/10ps
module dbu_debug_breakpoint_unit_tb;
  import dbu_pkg::*;
  logic clock_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [5:0] avs_address_in = 6'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out, rd_seen, q;
  logic avs_waitrequest_out, wr_seen;
  logic start_in, dr_access_in, retire_in, rep_incomplete_in, sets_tf_in;
  logic [63:0] start_ip_in, retire_ip_in, next_ip_in, mem_addr_in;
  logic mem_valid_in, mem_write_in, io_valid_in, task_switch_in;
  logic swap_break_in, ext_irq_in, exc_valid_out, exc_before_out;
  logic [1:0] mem_size_in, io_size_in;
  logic [15:0] io_port_in;
  logic [7:0] exc_vector_out;
  logic [63:0] exc_ret_ip_out;
  logic exc_tf_image_out, exc_irq_next_out, step_trap_flag_out;
  logic resume_flag_out;
  int n_mismatch = 0;
  int n_compared = 0;
  // Core clock, 4 ns period
  always #2 clock_in = ~clock_in;
  // Bus answer as it stands just before each rising edge
  always @(negedge clock_in) begin
    wr_seen = avs_waitrequest_out;
    rd_seen = avs_readdata_out;
  end
  dbu_debug_breakpoint_unit u_dut (
    .clock_in, .arst_n_in, .clk_en_in(1'b1), .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_byteenable_in(4'hf),
    .avs_readdata_out, .avs_waitrequest_out, .start_in, .start_ip_in,
    .dr_access_in, .retire_in, .retire_ip_in, .next_ip_in,
    .rep_incomplete_in, .sets_tf_in, .mem_valid_in, .mem_write_in,
    .mem_addr_in, .mem_size_in, .io_valid_in, .io_port_in, .io_size_in,
    .task_switch_in, .swap_break_in, .ext_irq_in, .exc_valid_out,
    .exc_vector_out, .exc_before_out, .exc_ret_ip_out, .exc_tf_image_out,
    .exc_irq_next_out, .step_trap_flag_out, .resume_flag_out);
  dbu_pipe_model u_pipe (
    .clock_in, .start_in, .start_ip_in, .dr_access_in, .retire_in,
    .retire_ip_in, .next_ip_in, .rep_incomplete_in, .sets_tf_in,
    .mem_valid_in, .mem_write_in, .mem_addr_in, .mem_size_in, .io_valid_in,
    .io_port_in, .io_size_in, .task_switch_in, .swap_break_in, .ext_irq_in);
  // Verdict and end of run
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Compare one value against its expectation
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int i;
    @(posedge clock_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= ~w;
    for (i = 0; i < 20; i++) begin
      @(posedge clock_in);
      if (!wr_seen) break;
    end
    if (i == 20) begin
      n_mismatch++;
      conclude();
    end else begin
      r = rd_seen;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic clr();
    wr(OFF_CTRL, 32'h0);
    wr(OFF_STAT, 32'h0);
    wr(OFF_FLAGS, 32'h0);
  endtask
  // Exception request one cycle after the instruction was taken
  task automatic obs(input logic v, input logic b, input logic [63:0] r);
    #1;
    chk(exc_valid_out, v);
    if (v) begin
      chk(exc_vector_out, DBG_VECTOR);
      chk(exc_before_out, b);
      chk(exc_ret_ip_out, r);
    end
  endtask
  task automatic t_exec();
    rd(OFF_CTRL, CTRL_RST);
    wr(6'h2c, 32'hffff_ffff);
    rd(6'h2c, 32'h0);
    wr(OFF_BP_BASE, 32'h1000);
    wr(6'h04, 32'h0);
    u_pipe.pre(64'h1000, 1'b0);
    obs(1'b0, 1'b0, 64'h0);
    wr(OFF_CTRL, 32'h1);
    u_pipe.pre(64'h1000, 1'b0);
    obs(1'b1, 1'b1, 64'h1000);
    rd(OFF_STAT, 32'h1);
    wr(OFF_FLAGS, 32'h2);
    u_pipe.pre(64'h1000, 1'b0);
    obs(1'b0, 1'b0, 64'h0);
    u_pipe.post(64'h1000, 8'h00, 64'h0, 2'h0);
    obs(1'b0, 1'b0, 64'h0);
    chk(resume_flag_out, 1'b0);
    wr(OFF_CTRL, 32'h2);
    u_pipe.pre(64'h1000, 1'b0);
    obs(1'b1, 1'b1, 64'h1000);
    $display("test exec done");
  endtask
  task automatic t_data();
    clr();
    wr(6'h08, 32'hf004);
    wr(6'h0c, 32'h0);
    wr(OFF_CTRL, 32'h00d0_0004);
    u_pipe.post(64'h2000, 8'h03, 64'hf005, 2'h2);
    obs(1'b1, 1'b0, 64'h2004);
    rd(OFF_STAT, 32'h2);
    u_pipe.post(64'h2000, 8'h02, 64'hf005, 2'h2);
    obs(1'b0, 1'b0, 64'h0);
    u_pipe.post(64'h2000, 8'h03, 64'heffe, 2'h2);
    obs(1'b0, 1'b0, 64'h0);
    u_pipe.post(64'h2000, 8'h0b, 64'hf007, 2'h0);
    obs(1'b1, 1'b0, 64'h2000);
    wr(6'h08, 32'hf005);
    wr(OFF_CTRL, 32'h00b0_0004); // Eight bytes, long mode assumed
    u_pipe.post(64'h2000, 8'h02, 64'heffb, 2'h3);
    obs(1'b1, 1'b0, 64'h2004);
    wr(OFF_BP_BASE, 32'h2004);
    wr(OFF_CTRL, 32'h00b0_0005);
    fork
      u_pipe.post(64'h2000, 8'h02, 64'hf000, 2'h0);
      u_pipe.pre(64'h2004, 1'b0);
    join
    obs(1'b1, 1'b0, 64'h2004);
    u_pipe.pre(64'h2004, 1'b0);
    obs(1'b1, 1'b1, 64'h2004);
    u_pipe.post(64'h2004, 8'h02, 64'hf000, 2'h0);
    obs(1'b1, 1'b0, 64'h2008);
    $display("test data done");
  endtask
  task automatic t_io();
    clr();
    wr(6'h10, 32'h60);
    wr(6'h14, 32'h0);
    wr(OFF_CTRL, 32'h0600_0010);
    u_pipe.post(64'h3000, 8'h04, 64'h60, 2'h1);
    obs(1'b0, 1'b0, 64'h0);
    wr(OFF_FLAGS, 32'h4);
    u_pipe.post(64'h3000, 8'h04, 64'h60, 2'h1);
    obs(1'b1, 1'b0, 64'h3004);
    rd(OFF_STAT, 32'h4);
    repeat (2) begin
      u_pipe.post(64'h3000, 8'h0c, 64'h60, 2'h1);
      obs(1'b1, 1'b0, 64'h3000);
    end
    $display("test io done");
  endtask
  task automatic t_step();
    clr();
    wr(OFF_FLAGS, 32'h1);
    u_pipe.post(64'h4000, 8'h10, 64'h0, 2'h0);
    obs(1'b0, 1'b0, 64'h0);
    u_pipe.post(64'h4004, 8'h00, 64'h0, 2'h0);
    obs(1'b0, 1'b0, 64'h0);
    u_pipe.post(64'h4008, 8'h80, 64'h0, 2'h0);
    obs(1'b1, 1'b0, 64'h400c);
    chk(exc_tf_image_out, 1'b1);
    chk(exc_irq_next_out, 1'b1);
    chk(step_trap_flag_out, 1'b0);
    rd(OFF_STAT, 32'h4000);
    $display("test step done");
  endtask
  task automatic t_guard_task();
    clr();
    wr(OFF_CTRL, 32'h2000);
    u_pipe.pre(64'h5000, 1'b1);
    obs(1'b1, 1'b1, 64'h5000);
    rd(OFF_CTRL, 32'h0);
    rd(OFF_STAT, 32'h2000);
    clr();
    wr(OFF_CTRL, 32'h0000_00ff);
    u_pipe.post(64'h6000, 8'h60, 64'h0, 2'h0);
    obs(1'b1, 1'b0, 64'h6004);
    rd(OFF_CTRL, 32'haa);
    rd(OFF_STAT, 32'h8000);
    $display("test guard and task done");
  endtask
  // Reset, then the scenarios in turn
  initial begin
    repeat (12) @(posedge clock_in);
    arst_n_in <= 1'b1;
    t_exec();
    t_data();
    t_io();
    t_step();
    t_guard_task();
    conclude();
  end
endmodule // dbu_debug_breakpoint_unit_tb
